// [inc/t8w_pkg.sv]
package t8w_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [7:0] T8W_ADDR_CTRL = 8'h00;
	localparam logic [7:0] T8W_ADDR_COUNT = 8'h04;
	localparam logic [7:0] T8W_ADDR_COMPARE = 8'h08;
	localparam logic [7:0] T8W_ADDR_FLAGS = 8'h0c;
	localparam logic [7:0] T8W_ADDR_PINDIR = 8'h10;

	// ==========================================================
	// Reset values and counter limits
	localparam logic [7:0] T8W_RST_CTRL = 8'h00;
	localparam logic [7:0] T8W_RST_BYTE = 8'h00;
	localparam logic [7:0] T8W_BOTTOM = 8'h00;
	localparam logic [7:0] T8W_MAX = 8'hff;

	// ==========================================================
	// Field positions
	localparam int T8W_FORCE_BIT = 7;
	localparam int T8W_COM_LSB = 4;
	localparam int T8W_FLAG_OVF_BIT = 0;
	localparam int T8W_FLAG_CMP_BIT = 1;

	// ==========================================================
	// Wave mode select codes
	localparam logic [1:0] T8W_MODE_NORMAL = 2'h0;
	localparam logic [1:0] T8W_MODE_PCPWM = 2'h1;
	localparam logic [1:0] T8W_MODE_CTC = 2'h2;
	localparam logic [1:0] T8W_MODE_FAST = 2'h3;

	// ==========================================================
	// Output action select codes
	localparam logic [1:0] T8W_COM_OFF = 2'h0;
	localparam logic [1:0] T8W_COM_TOGGLE = 2'h1;
	localparam logic [1:0] T8W_COM_CLEAR = 2'h2;
	localparam logic [1:0] T8W_COM_SET = 2'h3;

	// ==========================================================
	// Clock select codes and prescaler tap masks
	localparam logic [2:0] T8W_CS_STOP = 3'h0;
	localparam logic [2:0] T8W_CS_DIV1 = 3'h1;
	localparam logic [2:0] T8W_CS_DIV8 = 3'h2;
	localparam logic [2:0] T8W_CS_DIV64 = 3'h3;
	localparam logic [2:0] T8W_CS_DIV256 = 3'h4;
	localparam logic [2:0] T8W_CS_DIV1024 = 3'h5;
	localparam logic [2:0] T8W_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] T8W_CS_EXT_RISE = 3'h7;
	localparam logic [9:0] T8W_MASK8 = 10'h007;
	localparam logic [9:0] T8W_MASK64 = 10'h03f;
	localparam logic [9:0] T8W_MASK256 = 10'h0ff;
	localparam logic [9:0] T8W_MASK1024 = 10'h3ff;

	// ==========================================================
	// Timing figures and bus responses
	localparam logic [8:0] T8W_PC_PERIOD_LAST = 9'h1fd;
	localparam logic [1:0] T8W_RESP_OKAY = 2'h0;
	localparam logic [1:0] T8W_RESP_SLVERR = 2'h2;

	// Timer control register layout
	typedef struct packed {
		logic force_compare_strobe;
		logic wave_mode_low;
		logic [1:0] output_action_sel;
		logic wave_mode_high;
		logic [2:0] clock_sel;
	} t8w_ctrl_s;

endpackage

// [src/t8w_top.sv]
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps

module t8w_top
	import t8w_pkg::*;
(
	input wire logic aclk, // Bus and timer clock
	input wire logic aresetn, // Synchronous reset, low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic ext_tick_pin, // External count source pin
	output logic wave_pin_out, // Pin level from wave output
	output logic wave_pin_oe_n, // Pin enable, low drives
	output logic overflow_flag, // Sticky overflow flag
	output logic compare_flag // Sticky compare flag
);

	// ==========================================================
	// Decode helpers
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == T8W_ADDR_CTRL) || (a == T8W_ADDR_COUNT) ||
			(a == T8W_ADDR_COMPARE) || (a == T8W_ADDR_FLAGS) ||
			(a == T8W_ADDR_PINDIR);
	endfunction

	function automatic logic is_pwm(input logic [1:0] m);
		is_pwm = (m == T8W_MODE_PCPWM) || (m == T8W_MODE_FAST);
	endfunction

	function automatic logic match_act(input logic [1:0] c, input logic cur);
		case (c)
			T8W_COM_TOGGLE: match_act = ~cur;
			T8W_COM_CLEAR: match_act = 1'b0;
			T8W_COM_SET: match_act = 1'b1;
			default: match_act = cur;
		endcase
	endfunction

	// ==========================================================
	// State
	t8w_ctrl_s ctrl;
	logic [7:0] count_value;
	logic [7:0] compare_value;
	logic [7:0] ocr_act;
	logic port_dir;
	logic dir_up;
	logic blk;
	logic wave_out;
	logic [9:0] psc;
	logic ext_s1, ext_s2, ext_s3, ext_lvl;
	logic aw_got, w_got;
	logic [7:0] aw_addr;
	logic [7:0] w_data;
	logic w_strb0;
	logic rd_ctrl;

	logic [1:0] mode;
	logic [1:0] com;
	logic aw_hs, w_hs, ar_hs, wr_fire, wr_en;
	logic wr_ctrl, wr_count, wr_compare, wr_flags, wr_pindir;
	logic force_hit;
	logic tick, ext_edge;
	logic match, ovf_set, cmp_set, bottom_evt;
	logic up_res, down_res, connected;
	logic [7:0] next_count;
	logic next_dir_up;
	logic [7:0] rd_mux;

	assign mode = {ctrl.wave_mode_high, ctrl.wave_mode_low};
	assign com = ctrl.output_action_sel;

	// ==========================================================
	// AXI4-Lite handshakes
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
	assign wr_en = wr_fire & w_strb0;
	assign wr_ctrl = wr_en & (aw_addr == T8W_ADDR_CTRL);
	assign wr_count = wr_en & (aw_addr == T8W_ADDR_COUNT);
	assign wr_compare = wr_en & (aw_addr == T8W_ADDR_COMPARE);
	assign wr_flags = wr_en & (aw_addr == T8W_ADDR_FLAGS);
	assign wr_pindir = wr_en & (aw_addr == T8W_ADDR_PINDIR);

	// Write address and data captured in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= T8W_RST_BYTE;
			w_data <= T8W_RST_BYTE;
			w_strb0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= T8W_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= ~aw_got & ~aw_hs & ~s_axi_bvalid;
			s_axi_wready <= ~w_got & ~w_hs & ~s_axi_bvalid;
			if (aw_hs)
			begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_hs)
			begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata[7:0];
				w_strb0 <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok(aw_addr) ? T8W_RESP_OKAY :
					T8W_RESP_SLVERR;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read data mux, narrow registers in the low byte
	always_comb
	begin
		case (s_axi_araddr)
			T8W_ADDR_CTRL: rd_mux = {1'b0, ctrl[6:0]};
			T8W_ADDR_COUNT: rd_mux = count_value;
			T8W_ADDR_COMPARE: rd_mux = compare_value;
			T8W_ADDR_FLAGS: rd_mux = {6'h00, compare_flag, overflow_flag};
			T8W_ADDR_PINDIR: rd_mux = {7'h00, port_dir};
			default: rd_mux = T8W_RST_BYTE;
		endcase
	end

	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= T8W_RESP_OKAY;
			rd_ctrl <= 1'b0;
		end
		else
		begin
			s_axi_arready <= ~ar_hs & ~s_axi_rvalid;
			if (ar_hs)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_mux};
				s_axi_rresp <= addr_ok(s_axi_araddr) ? T8W_RESP_OKAY :
					T8W_RESP_SLVERR;
				rd_ctrl <= (s_axi_araddr == T8W_ADDR_CTRL);
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= T8W_RST_CTRL;
			compare_value <= T8W_RST_BYTE;
			port_dir <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= {1'b0, w_data[6:0]};
			if (wr_compare)
				compare_value <= w_data;
			if (wr_pindir)
				port_dir <= w_data[0];
		end
	end

	// In PWM modes the force strobe is ignored; the rest of the write still loads ctrl
	assign force_hit = wr_ctrl & w_data[T8W_FORCE_BIT] &
		~is_pwm({w_data[3], w_data[6]});

	// ==========================================================
	// Tick generation: prescaler taps and filtered external pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			psc <= 10'h000;
		else
			psc <= psc + 10'h001;
	end

	// Three-stage pin sync; level accepted when stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			ext_lvl <= 1'b0;
		end
		else
		begin
			ext_s1 <= ext_tick_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			if (ext_s2 == ext_s3)
				ext_lvl <= ext_s3;
		end
	end

	assign ext_edge = (ext_s2 == ext_s3) & (ext_s3 != ext_lvl);

	always_comb
	begin
		case (ctrl.clock_sel)
			T8W_CS_DIV1: tick = 1'b1;
			T8W_CS_DIV8: tick = (psc & T8W_MASK8) == T8W_MASK8;
			T8W_CS_DIV64: tick = (psc & T8W_MASK64) == T8W_MASK64;
			T8W_CS_DIV256: tick = (psc & T8W_MASK256) == T8W_MASK256;
			T8W_CS_DIV1024: tick = psc == T8W_MASK1024;
			T8W_CS_EXT_FALL: tick = ext_edge & ~ext_s3;
			T8W_CS_EXT_RISE: tick = ext_edge & ext_s3;
			default: tick = 1'b0;
		endcase
	end

	// ==========================================================
	// Counter sequencing
	assign match = (count_value == ocr_act) & ~blk;

	always_comb
	begin
		next_count = count_value;
		next_dir_up = 1'b1;
		case (mode)
			T8W_MODE_PCPWM:
			begin
				next_dir_up = dir_up;
				if (dir_up && count_value == T8W_MAX)
				begin
					next_count = T8W_MAX - 8'h01;
					next_dir_up = 1'b0;
				end
				else if (!dir_up && count_value == T8W_BOTTOM)
				begin
					next_count = T8W_BOTTOM + 8'h01;
					next_dir_up = 1'b1;
				end
				else if (dir_up)
					next_count = count_value + 8'h01;
				else
					next_count = count_value - 8'h01;
			end
			T8W_MODE_CTC:
				next_count = (count_value == ocr_act) ? T8W_BOTTOM :
					count_value + 8'h01;
			default: next_count = count_value + 8'h01;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_value <= T8W_BOTTOM;
			dir_up <= 1'b1;
			blk <= 1'b0;
		end
		else if (wr_count)
		begin
			count_value <= w_data;
			blk <= 1'b1;
		end
		else
		begin
			if (tick)
			begin
				count_value <= next_count;
				dir_up <= next_dir_up;
				blk <= 1'b0;
			end
			else if (mode != T8W_MODE_PCPWM)
				dir_up <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ocr_act <= T8W_RST_BYTE;
		else if (!is_pwm(mode))
			ocr_act <= compare_value;
		else if (tick && count_value == T8W_MAX)
			ocr_act <= compare_value;
	end

	// ==========================================================
	// Flags: hardware set wins over a software write-one clear
	// bottom overflow in PC
	assign bottom_evt = tick & ~dir_up & (count_value == T8W_BOTTOM);
	assign ovf_set = (mode == T8W_MODE_PCPWM) ? bottom_evt :
		tick & (count_value == T8W_MAX);
	assign cmp_set = tick & match;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			overflow_flag <= 1'b0;
			compare_flag <= 1'b0;
		end
		else
		begin
			overflow_flag <= ovf_set | (overflow_flag &
				~(wr_flags & w_data[T8W_FLAG_OVF_BIT]));
			compare_flag <= cmp_set | (compare_flag &
				~(wr_flags & w_data[T8W_FLAG_CMP_BIT]));
		end
	end

	// ==========================================================
	// Wave output generation
	// action 3 inverts in PWM modes; in normal and CTC it sets on match
	assign up_res = (com == T8W_COM_SET);
	assign down_res = (com == T8W_COM_CLEAR);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wave_out <= 1'b0;
		else if (force_hit)
			wave_out <= match_act(w_data[5:4], wave_out);
		else if (tick)
		begin
			case (mode)
				T8W_MODE_FAST:
				begin
					if (com[1] && count_value == T8W_MAX)
						wave_out <= down_res;
					else if (com[1] && match)
						wave_out <= up_res;
				end
				T8W_MODE_PCPWM:
				begin
					if (com[1] && count_value == T8W_MAX)
						wave_out <= (compare_value == T8W_MAX) ?
							down_res : up_res;
					else if (com[1] && match)
						wave_out <= (dir_up ||
							count_value == T8W_BOTTOM) ? up_res : down_res;
				end
				default:
					if (match)
						wave_out <= match_act(com, wave_out);
			endcase
		end
	end

	assign connected = (com != T8W_COM_OFF) &&
		!(is_pwm(mode) && com == T8W_COM_TOGGLE);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wave_pin_out <= 1'b0;
			wave_pin_oe_n <= 1'b1;
		end
		else
		begin
			wave_pin_out <= wave_out;
			wave_pin_oe_n <= ~(connected & port_dir);
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [8:0] per_cnt;
	logic per_valid;
	logic pc_mode;
	assign pc_mode = (mode == T8W_MODE_PCPWM);

	// Tick count between phase-correct bottoms
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !pc_mode || wr_count)
		begin
			per_cnt <= 9'h000;
			per_valid <= 1'b0;
		end
		else if (bottom_evt)
		begin
			per_cnt <= 9'h000;
			per_valid <= 1'b1;
		end
		else if (tick)
			per_cnt <= per_cnt + 9'h001;
	end

	property p_top_turn;
		pc_mode && tick && !wr_count && dir_up && count_value == T8W_MAX
		|=> count_value == 8'hfe && !dir_up;
	endproperty
	a_top_turn: assert property (p_top_turn)
		else $error("counter did not turn at MAX");

	property p_bottom_ovf;
		pc_mode && bottom_evt |=> overflow_flag;
	endproperty
	a_bottom_ovf: assert property (p_bottom_ovf)
		else $error("overflow flag not set at BOTTOM");

	property p_up_clear;
		pc_mode && tick && !force_hit && match && dir_up &&
		count_value != T8W_BOTTOM && count_value != T8W_MAX &&
		com == T8W_COM_CLEAR |=> !wave_out;
	endproperty
	a_up_clear: assert property (p_up_clear)
		else $error("up match did not clear wave output");

	property p_top_level;
		pc_mode && tick && !force_hit && count_value == T8W_MAX &&
		com == T8W_COM_CLEAR |=> wave_out == (ocr_act == T8W_MAX);
	endproperty
	a_top_level: assert property (p_top_level)
		else $error("wrong wave level at MAX");

	property p_period;
		bottom_evt && per_valid |-> per_cnt == T8W_PC_PERIOD_LAST;
	endproperty
	a_period: assert property (p_period)
		else $error("phase-correct period is not 510 ticks");

	property p_force_pwm;
		wr_ctrl && w_data[T8W_FORCE_BIT] &&
		is_pwm({w_data[3], w_data[6]}) && !tick |=> $stable(wave_out);
	endproperty
	a_force_pwm: assert property (p_force_pwm)
		else $error("force strobe acted in PWM mode");

	property p_force_noflag;
		force_hit && !tick |=> $stable(compare_flag) &&
		$stable(count_value);
	endproperty
	a_force_noflag: assert property (p_force_noflag)
		else $error("force strobe set flag or cleared counter");

	property p_force_read;
		s_axi_rvalid && rd_ctrl |-> !s_axi_rdata[T8W_FORCE_BIT];
	endproperty
	a_force_read: assert property (p_force_read)
		else $error("force strobe bit read as one");

	property p_pin_off;
		!port_dir |=> wave_pin_oe_n;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("pin driven while direction is input");

	property p_reset_zero;
		!$past(aresetn) |-> ctrl == T8W_RST_CTRL && wave_pin_oe_n;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("control not zero after reset");

	property p_cov_top;
		pc_mode && tick && count_value == T8W_MAX;
	endproperty
	c_cov_top: cover property (p_cov_top);

	property p_cov_force;
		force_hit;
	endproperty
	c_cov_force: cover property (p_cov_force);

	property p_cov_period;
		bottom_evt && per_valid;
	endproperty
	c_cov_period: cover property (p_cov_period);

	property p_cov_pin;
		pc_mode && !wave_pin_oe_n ##1 $changed(wave_pin_out);
	endproperty
	c_cov_pin: cover property (p_cov_pin);

endmodule // t8w_top

// [testbench/t8w_pin_load.sv]
`timescale 1ns/100ps

// ====================
// Pin with a PWM load, no pull resistor
module t8w_pin_load
	import t8w_pkg::*;
(
	input wire logic aclk, // Timer clock
	input wire logic wave_pin_out, // Level from the generator
	input wire logic wave_pin_oe_n, // Enable, low drives
	output logic pin_level, // Level seen by the load
	output logic pin_driven // High while the generator drives
);
	logic float_q = 1'b0;

	// Undriven pin wanders every cycle
	always_ff @(posedge aclk)
		float_q <= ~float_q;

	assign pin_driven = (wave_pin_oe_n == 1'b0);
	assign pin_level = pin_driven ? wave_pin_out : float_q;
endmodule // t8w_pin_load

// [testbench/tb_timer8_waveform_modes.sv]
`timescale 1ns/100ps

// ====================
// Bench for the phase-correct, fast PWM and CTC wave generator
module tb_timer8_waveform_modes
	import t8w_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdat, seed;
	logic [1:0] rsp;
	logic awready, wready, bvalid, arready, rvalid, pin_out, oe_n;
	logic ovf, cmpf, pin_level, pin_driven;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int fail_count, check_count, cyc, t1, hi, und, act, win;
	int cases[$];

	t8w_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_tick_pin(ext), .wave_pin_out(pin_out),
		.wave_pin_oe_n(oe_n), .overflow_flag(ovf), .compare_flag(cmpf));

	t8w_pin_load u_load (.aclk(aclk), .wave_pin_out(pin_out),
		.wave_pin_oe_n(oe_n), .pin_level(pin_level),
		.pin_driven(pin_driven));

	// ====================
	// Clock and cycle count
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	always @(posedge aclk)
		cyc <= cyc + 1;

	// ====================
	// Checking and ending
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task guard(input int n);
		if (n > 2000)
		begin
			fail_count++;
			$display("[FAIL] wait expected done seen timeout");
			give_verdict();
		end
	endtask

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Model: high ticks per window, phase-correct 510 or fast 256
	function int exp_high(input int c, input int a, input int w);
		if (w == 510)
			return (a == 2) ? 2 * c : 510 - 2 * c;
		return (a == 2) ? c + 1 : 255 - c;
	endfunction

	// ====================
	// Bus master tasks
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			guard(n);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			rsp = bresp;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			guard(n);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			rdat = rdata;
			rsp = rresp;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task wait_ovf();
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			guard(n);
		end while (ovf !== 1'b1);
	endtask

	task settle();
		repeat (3) @(posedge aclk);
	endtask

	// ====================
	// Main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ext} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		seed = 32'h44bf88b7;
		cyc = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++)
		begin
			rd(8'(4 * i));
			check("reset value", rdat, 32'h0);
		end
		check("oe_n", oe_n, 1'b1);
		rd(8'h14);
		check("rresp unmapped", rsp, T8W_RESP_SLVERR);
		wr(8'h14, 32'hff);
		check("bresp unmapped", rsp, T8W_RESP_SLVERR);
		$display("test reset done");

		wr(T8W_ADDR_CTRL, 32'hf8);
		rd(T8W_ADDR_CTRL);
		check("ctrl readback", rdat, 32'h78);
		$display("test control done");

		// Forced compares, counter stopped
		wr(T8W_ADDR_PINDIR, 32'h1);
		wr(T8W_ADDR_CTRL, 32'hb0);
		settle();
		check("force set", pin_level, 1'b1);
		wr(T8W_ADDR_CTRL, 32'ha8);
		settle();
		check("force clear", pin_level, 1'b0);
		wr(T8W_ADDR_CTRL, 32'hf0);
		settle();
		check("force in pwm", pin_level, 1'b0);
		rd(T8W_ADDR_FLAGS);
		check("force flags", rdat, 32'h0);
		rd(T8W_ADDR_COUNT);
		check("force count", rdat, 32'h0);
		check("force cmp flag", cmpf, 1'b0);
		$display("test force done");

		// Duty per compare value and polarity
		cases = {0, 1, 100, 255};
		seed = lfsr(seed);
		cases.push_back(int'(seed[7:0]));
		seed = lfsr(seed);
		cases.push_back(int'(seed[7:0]));
		wr(T8W_ADDR_CTRL, 32'h0);
		wr(T8W_ADDR_COUNT, 32'h0);
		foreach (cases[k])
			for (int md = 0; md < 4; md++)
			begin
				act = 2 + md % 2;
				win = (md < 2) ? 510 : 256;
				wr(T8W_ADDR_COMPARE, 32'(cases[k]));
				wr(T8W_ADDR_CTRL, ((md < 2) ? 32'h41 : 32'h49) |
					32'(act << 4));
				repeat (600) @(posedge aclk);
				hi = 0;
				und = 0;
				repeat (win)
				begin
					@(posedge aclk);
					if (pin_level === 1'b1)
						hi++;
					if (pin_driven !== 1'b1)
						und++;
				end
				check("undriven", 32'(und), 32'h0);
				t1 = exp_high(cases[k], act, win);
				check("duty", 32'(hi), 32'(t1));
			end
		$display("test duty done");

		// Overflow once per period
		wr(T8W_ADDR_CTRL, 32'h61);
		wr(T8W_ADDR_FLAGS, 32'h1);
		wait_ovf();
		wr(T8W_ADDR_FLAGS, 32'h1);
		wait_ovf();
		t1 = cyc;
		wr(T8W_ADDR_FLAGS, 32'h1);
		check("ovf cleared", ovf, 1'b0);
		wait_ovf();
		check("period", 32'(cyc - t1), 32'd510);
		$display("test period done");

		// Disconnected cases
		wr(T8W_ADDR_CTRL, 32'h41);
		settle();
		check("action 0", pin_driven, 1'b0);
		wr(T8W_ADDR_CTRL, 32'h51);
		settle();
		check("action 1", pin_driven, 1'b0);
		wr(T8W_ADDR_CTRL, 32'h61);
		wr(T8W_ADDR_PINDIR, 32'h0);
		settle();
		check("pin input", pin_driven, 1'b0);
		$display("test disconnect done");

		// Toggle on match with compare as TOP
		seed = lfsr(seed);
		wr(T8W_ADDR_COMPARE, 32'(seed[3:0]));
		wr(T8W_ADDR_PINDIR, 32'h1);
		wr(T8W_ADDR_FLAGS, 32'h3);
		wr(T8W_ADDR_CTRL, 32'h19);
		repeat (300) @(posedge aclk);
		hi = 0;
		und = int'(pin_level);
		repeat (10 * (int'(seed[3:0]) + 1))
		begin
			@(posedge aclk);
			if (int'(pin_level) != und)
				hi++;
			und = int'(pin_level);
		end
		check("toggles", 32'(hi), 32'd10);
		check("cmp flag", cmpf, 1'b1);
		$display("test toggle done");

		// External rising, then falling edges as ticks
		wr(T8W_ADDR_CTRL, 32'h0);
		wr(T8W_ADDR_COUNT, 32'h0);
		for (int cs = 7; cs > 5; cs--)
		begin
			wr(T8W_ADDR_CTRL, 32'(cs));
			repeat (5)
			begin
				repeat (8) @(posedge aclk);
				ext <= 1'b1;
				repeat (8) @(posedge aclk);
				ext <= 1'b0;
			end
			repeat (8) @(posedge aclk);
			wr(T8W_ADDR_CTRL, 32'h0);
			rd(T8W_ADDR_COUNT);
			check("ext count", rdat, 32'(5 * (8 - cs)));
		end
		$display("test external done");
		give_verdict();
	end
endmodule // tb_timer8_waveform_modes
